/* File: bsmc_pkg.sv */
// shared constants for the brown-out and supply warning control
package bsmc_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 50_000_000; // system clock rate
	localparam int unsigned CLK_PERIOD_NS = 20; // one clock period
	localparam int unsigned SAMP_FAST_HZ = 1000; // fast sample rate
	localparam int unsigned SAMP_SLOW_HZ = 125; // slow sample rate
	localparam int unsigned SAMP_FAST_CYC = CLK_HZ / SAMP_FAST_HZ; // fast sample period
	localparam int unsigned SAMP_SLOW_CYC = CLK_HZ / SAMP_SLOW_HZ; // slow sample period
	localparam int unsigned SAMP_W = 19; // width of the period counter
	localparam int unsigned PROBE_ON_NS = 1000; // detector power window per sample
	localparam int unsigned PROBE_ON_CYC = (PROBE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STARTUP_NS = 2000; // detector start-up at wake
	localparam int unsigned STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WIN_W = 8; // width of the window and hold counters
	// register indices, byte address is four times the index
	localparam logic [3:0] REG_MODE_CTRL = 4'h0;
	localparam logic [3:0] REG_LEVEL_CTRL = 4'h1;
	localparam logic [3:0] REG_WARN_LEVEL = 4'h8;
	localparam logic [3:0] REG_WARN_IRQ_CTRL = 4'h9;
	localparam logic [3:0] REG_WARN_FLAGS = 4'ha;
	localparam logic [3:0] REG_WARN_STATUS = 4'hb;
	// field positions
	localparam int unsigned MODE_SLEEP_LSB = 0;
	localparam int unsigned MODE_ACTIVE_LSB = 2;
	localparam int unsigned MODE_SAMPFREQ_BIT = 4;
	localparam int unsigned IRQ_IE_BIT = 0;
	localparam int unsigned IRQ_TRIG_LSB = 1;
	localparam int unsigned FLAG_BIT = 0;
	localparam int unsigned STATUS_BIT = 0;
	// reset values
	localparam logic [1:0] WARN_LEVEL_RST = 2'h0;
	localparam logic [1:0] TRIG_RST = 2'h0;
	localparam logic IE_RST = 1'h0;
	// warning margin in percent per code
	localparam logic [4:0] MARGIN_PCT_0 = 5'h05;
	localparam logic [4:0] MARGIN_PCT_1 = 5'h0f;
	localparam logic [4:0] MARGIN_PCT_2 = 5'h19;
	// detector operating modes
	typedef enum logic [1:0] {
		BSMC_OFF = 2'b00,
		BSMC_CONT = 2'b01,
		BSMC_SAMP = 2'b10,
		BSMC_CONT_HOLD = 2'b11
	} bsmc_mode_type;
	// warning trigger directions
	typedef enum logic [1:0] {
		BSMC_BELOW = 2'b00,
		BSMC_ABOVE = 2'b01,
		BSMC_CROSS = 2'b10,
		BSMC_TRIG_RSVD = 2'b11
	} bsmc_trig_type;
endpackage

/* File: bsmc_supply_model.sv */
`timescale 1ns/1ps
// comparator pair seen from the supply side
module bsmc_supply_model (
	// clock
	input wire logic clk_i,
	// supply band: 0 above warning, 1 between, 2 below brown-out
	input wire logic [1:0] supply_lvl_i,
	// comparator power from the block
	input wire logic bod_power_i,
	input wire logic warn_power_i,
	// comparator outputs, 1 = supply below
	output logic bod_below_o,
	output logic warn_below_o
);
	initial begin
		bod_below_o = 1'b0;
		warn_below_o = 1'b0;
	end
	// unpowered comparator gives a flipping pattern, never a held value
	always @(posedge clk_i) begin
		if (bod_power_i) begin
			bod_below_o <= (supply_lvl_i == 2'h2);
		end else begin
			bod_below_o <= ~bod_below_o;
		end
		if (warn_power_i) begin
			warn_below_o <= (supply_lvl_i != 2'h0);
		end else begin
			warn_below_o <= ~warn_below_o;
		end
	end
endmodule

/* File: bsmc_top.sv */
// Summary of operation
// RULE1 - load level and modes from fuses
// RULE2 - level and active mode never software written
// RULE3 - sleep mode starts at fuse, software changeable
// RULE4 - deep sleep entry uses the sleep mode
// RULE5 - wake returns to the active mode
// RULE6 - continuous compare, or brief periodic sampling
// RULE7 - supply below threshold asserts system reset
// RULE8 - enable bit turns on warning monitor
// RULE9 - warning monitor off while detector off
// RULE10 - sampled detector samples warning monitor too
// RULE11 - warning margin chosen by margin field
// RULE12 - flag set on selected crossing direction
// RULE13 - request equals flag and enable
// RULE14 - request holds until flag cleared
// RULE15 - no request while processor debug halted
// RULE16 - software unlocks, then writes within four
// RULE17 - unlocked-less protected write is ignored
// RULE18 - only sleep mode field is protected
// RULE19 - mode codes off, continuous, sampled, hold
// RULE20 - trigger codes below, above, either direction
// RULE21 - margin codes five, fifteen, twentyfive percent
// RULE22 - flag updates only while detector enabled
// RULE23 - writing one clears flag, zero ignored
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module bsmc_top #(
	parameter int unsigned SAMP_FAST_CYCLES = bsmc_pkg::SAMP_FAST_CYC,
	parameter int unsigned SAMP_SLOW_CYCLES = bsmc_pkg::SAMP_SLOW_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// configuration fuses, static
	input wire logic [2:0] fuse_level_i,
	input wire logic [1:0] fuse_active_i,
	input wire logic [1:0] fuse_sleep_i,
	input wire logic fuse_sampfreq_i,
	// system state
	input wire logic deep_sleep_i,
	input wire logic debug_halt_i,
	input wire logic config_change_guard_i,
	// analog comparators, asynchronous
	input wire logic bod_below_i,
	input wire logic warn_below_i,
	// analog control and system outputs
	output logic bod_power_o,
	output logic [2:0] bod_level_o,
	output logic warn_power_o,
	output logic [4:0] warn_margin_pct_o,
	output logic sys_reset_o,
	output logic cpu_hold_o,
	output logic irq_o
);
	import bsmc_pkg::*;

	// fuse-loaded and software state
	logic [2:0] level; // detector threshold code
	bsmc_mode_type active_mode; // mode while running
	bsmc_mode_type sleep_mode; // mode in deep sleep
	logic sampfreq; // 1 selects the slow sample rate
	logic [1:0] margin_sel; // warning margin code
	bsmc_trig_type trig_sel; // warning direction
	logic irq_en; // warning enable
	logic flag; // warning flag
	logic warn_state; // last evaluated warning level, 1 below
	logic sleep_q; // deep sleep seen last cycle
	logic [SAMP_W-1:0] period_cnt; // cycles to next sample
	logic [WIN_W-1:0] win_cnt; // remaining power window
	logic [WIN_W-1:0] hold_cnt; // remaining wake hold
	// next values
	logic [2:0] next_level;
	bsmc_mode_type next_active_mode, next_sleep_mode;
	logic next_sampfreq, next_irq_en, next_flag, next_warn_state, next_ack;
	logic [1:0] next_margin_sel;
	bsmc_trig_type next_trig_sel;
	logic [SAMP_W-1:0] next_period_cnt;
	logic [WIN_W-1:0] next_win_cnt, next_hold_cnt;
	logic [31:0] next_dat;
	logic next_bod_power, next_warn_power, next_sys_reset, next_irq;
	logic [4:0] next_margin_pct;
	// synchronisers for the comparator pins
	logic bod_meta, bod_below_s, warn_meta, warn_below_s;
	// decode helpers
	logic [3:0] idx; // register index
	logic access, wr; // answered access, accepted write
	bsmc_mode_type mode_eff; // mode in force now
	logic det_on, mon_on, eval, trig_hit, margin_ok;
	logic [SAMP_W-1:0] period_len;

	// comparator outputs are analog and asynchronous
	always_ff @(posedge clk_i) begin
		bod_meta <= bod_below_i;
		bod_below_s <= bod_meta;
		warn_meta <= warn_below_i;
		warn_below_s <= warn_meta;
	end

	// bus decode: data in the low byte, write lands on the ack edge
	assign idx = wb_adr_i[5:2];
	assign access = wb_cyc_i && wb_stb_i && wb_ack_o;
	assign wr = access && wb_we_i && wb_sel_i[0];

	// mode selection, reserved sleep code keeps the detector off
	always_comb begin
		// RULE4 deep sleep entry
		if (deep_sleep_i) begin
			mode_eff = (sleep_mode == BSMC_CONT_HOLD) ? BSMC_OFF : sleep_mode;
		// RULE5 back to active mode
		end else begin
			mode_eff = active_mode;
		end
	end

	// monitor gating and sample instants
	always_comb begin
		det_on = (mode_eff != BSMC_OFF);
		// RULE11 RULE21 margin code lookup
		unique case (margin_sel)
			2'h0: next_margin_pct = MARGIN_PCT_0;
			2'h1: next_margin_pct = MARGIN_PCT_1;
			2'h2: next_margin_pct = MARGIN_PCT_2;
			default: next_margin_pct = 5'h00;
		endcase
		margin_ok = (next_margin_pct != 5'h00);
		// RULE9 monitor needs the detector
		mon_on = det_on && irq_en && margin_ok;
		// RULE10 sampled mode evaluates at window end only
		eval = (mode_eff == BSMC_SAMP) ? (win_cnt == WIN_W'(1)) : det_on;
		// RULE20 direction decode
		unique case (trig_sel)
			BSMC_BELOW: trig_hit = !warn_state && warn_below_s;
			BSMC_ABOVE: trig_hit = warn_state && !warn_below_s;
			BSMC_CROSS: trig_hit = warn_state != warn_below_s;
			default: trig_hit = 1'b0;
		endcase
		period_len = sampfreq ? SAMP_W'(SAMP_SLOW_CYCLES - 1) : SAMP_W'(SAMP_FAST_CYCLES - 1);
	end

	// next values of timing, detector and warning state
	always_comb begin
		next_period_cnt = period_cnt;
		next_win_cnt = (win_cnt != '0) ? win_cnt - WIN_W'(1) : win_cnt;
		next_hold_cnt = (hold_cnt != '0) ? hold_cnt - WIN_W'(1) : hold_cnt;
		next_warn_state = warn_state;
		next_flag = flag;
		// RULE6 sampled mode powers the detector periodically
		if (mode_eff == BSMC_SAMP) begin
			if (period_cnt == '0) begin
				next_period_cnt = period_len;
				next_win_cnt = WIN_W'(PROBE_ON_CYC);
			end else begin
				next_period_cnt = period_cnt - SAMP_W'(1);
			end
		end else begin
			next_period_cnt = '0;
			next_win_cnt = '0;
		end
		// RULE19 hold mode stalls execution at wake
		if (sleep_q && !deep_sleep_i && active_mode == BSMC_CONT_HOLD) begin
			next_hold_cnt = WIN_W'(STARTUP_CYC);
		end
		// RULE22 state follows only while enabled
		if (eval && mon_on) begin
			next_warn_state = warn_below_s;
		end
		// RULE23 write one clears, set wins below
		if (wr && idx == REG_WARN_FLAGS && wb_dat_i[FLAG_BIT]) begin
			next_flag = 1'b0;
		end
		// RULE12 set on the selected crossing
		if (eval && mon_on && trig_hit) begin
			next_flag = 1'b1;
		end
		// RULE6 continuous power or the sample window
		next_bod_power = (mode_eff == BSMC_SAMP) ? (next_win_cnt != '0) : det_on;
		// RULE8 monitor powered with the detector
		next_warn_power = next_bod_power && mon_on;
		// RULE7 brown-out reset
		next_sys_reset = eval && det_on && bod_below_s;
	end

	// next values of the software registers and the bus answer
	always_comb begin
		// RULE2 level, active mode and sample rate stay as loaded
		next_level = level;
		next_active_mode = active_mode;
		next_sampfreq = sampfreq;
		next_sleep_mode = sleep_mode;
		next_margin_sel = margin_sel;
		next_trig_sel = trig_sel;
		next_irq_en = irq_en;
		next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
		next_dat = '0;
		// RULE17 protected write needs the unlock window
		if (wr && idx == REG_MODE_CTRL && config_change_guard_i) begin
			// RULE3 software changes the sleep mode
			next_sleep_mode = bsmc_mode_type'(wb_dat_i[MODE_SLEEP_LSB +: 2]);
		end
		// RULE18 no unlock on the other controls
		if (wr && idx == REG_WARN_LEVEL) begin
			next_margin_sel = wb_dat_i[1:0];
		end
		if (wr && idx == REG_WARN_IRQ_CTRL) begin
			next_trig_sel = bsmc_trig_type'(wb_dat_i[IRQ_TRIG_LSB +: 2]);
			next_irq_en = wb_dat_i[IRQ_IE_BIT];
		end
		// read data captured as the ack is raised
		unique case (idx)
			REG_MODE_CTRL: begin
				next_dat[MODE_SLEEP_LSB +: 2] = sleep_mode;
				next_dat[MODE_ACTIVE_LSB +: 2] = active_mode;
				next_dat[MODE_SAMPFREQ_BIT] = sampfreq;
			end
			REG_LEVEL_CTRL: next_dat[2:0] = level;
			REG_WARN_LEVEL: next_dat[1:0] = margin_sel;
			REG_WARN_IRQ_CTRL: begin
				next_dat[IRQ_TRIG_LSB +: 2] = trig_sel;
				next_dat[IRQ_IE_BIT] = irq_en;
			end
			REG_WARN_FLAGS: next_dat[FLAG_BIT] = flag;
			REG_WARN_STATUS: next_dat[STATUS_BIT] = warn_state;
			default: next_dat = '0;
		endcase
		// RULE13 RULE14 request from flag and enable, RULE15 masked in debug
		next_irq = next_flag && next_irq_en && !debug_halt_i;
	end

	// register all state and outputs except the comparator synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// RULE1 fuses loaded at every reset
			level <= fuse_level_i;
			active_mode <= bsmc_mode_type'(fuse_active_i);
			sleep_mode <= bsmc_mode_type'(fuse_sleep_i);
			sampfreq <= fuse_sampfreq_i;
			margin_sel <= WARN_LEVEL_RST;
			trig_sel <= bsmc_trig_type'(TRIG_RST);
			irq_en <= IE_RST;
			flag <= 1'b0;
			warn_state <= 1'b0;
			sleep_q <= 1'b0;
			period_cnt <= '0;
			win_cnt <= '0;
			hold_cnt <= '0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			bod_power_o <= 1'b0;
			bod_level_o <= '0;
			warn_power_o <= 1'b0;
			warn_margin_pct_o <= '0;
			sys_reset_o <= 1'b0;
			cpu_hold_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			level <= next_level;
			active_mode <= next_active_mode;
			sleep_mode <= next_sleep_mode;
			sampfreq <= next_sampfreq;
			margin_sel <= next_margin_sel;
			trig_sel <= next_trig_sel;
			irq_en <= next_irq_en;
			flag <= next_flag;
			warn_state <= next_warn_state;
			sleep_q <= deep_sleep_i;
			period_cnt <= next_period_cnt;
			win_cnt <= next_win_cnt;
			hold_cnt <= next_hold_cnt;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			bod_power_o <= next_bod_power;
			bod_level_o <= level;
			warn_power_o <= next_warn_power;
			warn_margin_pct_o <= next_margin_pct;
			sys_reset_o <= next_sys_reset;
			cpu_hold_o <= (next_hold_cnt != '0);
			irq_o <= next_irq;
		end
	end

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence mode_write_s;
		wr && idx == REG_MODE_CTRL;
	endsequence
	sequence no_flag_touch_s;
		!(wr && (idx == REG_WARN_FLAGS || idx == REG_WARN_IRQ_CTRL));
	endsequence

	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");
	fuse_load_a: assert property ( // RULE1
		$past(rst_i) |-> level == $past(fuse_level_i) && sampfreq == $past(fuse_sampfreq_i))
		else $error("fuse values not loaded at reset");
	level_fixed_a: assert property ( // RULE2
		!$past(rst_i) |-> $stable(level) && $stable(active_mode))
		else $error("fixed setting changed");
	sleep_guard_a: assert property ( // RULE17
		(mode_write_s and !config_change_guard_i) |=> $stable(sleep_mode))
		else $error("protected write without unlock took effect");
	sleep_write_a: assert property ( // RULE3
		(mode_write_s and config_change_guard_i) |=> sleep_mode == $past(wb_dat_i[1:0]))
		else $error("unlocked sleep mode write lost");
	irq_cause_a: assert property (irq_o |-> flag && irq_en) // RULE13
		else $error("request without flag and enable");
	irq_hold_a: assert property ( // RULE14
		(irq_o && !debug_halt_i) ##0 no_flag_touch_s |=> irq_o)
		else $error("request dropped before flag clear");
	debug_mask_a: assert property (debug_halt_i |=> !irq_o) // RULE15
		else $error("request raised while debug halted");
	warn_gate_a: assert property (mode_eff == BSMC_OFF |=> !warn_power_o && !bod_power_o) // RULE9
		else $error("monitor powered with detector off");
	warn_sample_a: assert property ($changed(warn_state) |-> $past(eval && mon_on)) // RULE10
		else $error("warning state moved outside a sample");
	reset_cause_a: assert property (sys_reset_o |-> $past(det_on && bod_below_s)) // RULE7
		else $error("system reset without brown-out");
	sleep_power_a: assert property ( // RULE4
		deep_sleep_i && sleep_mode == BSMC_CONT |=> bod_power_o)
		else $error("continuous sleep mode not powered");
	flag_set_a: assert property ( // RULE12
		eval && mon_on && trig_hit |=> flag)
		else $error("warning crossing lost");
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
	import bsmc_pkg::*;
	// clock, reset, bus
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [5:0] wb_adr = 6'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	// fuses and system state
	logic [2:0] fuse_level = 3'h5;
	logic [1:0] fuse_active = 2'h1;
	logic [1:0] fuse_sleep = 2'h2;
	logic fuse_sampfreq = 1'b0;
	logic deep_sleep = 1'b0;
	logic debug_halt = 1'b0;
	logic guard = 1'b0;
	logic [1:0] supply_lvl = 2'h0;
	// analog side and outputs
	logic bod_below, warn_below, bod_power, warn_power, sys_reset, cpu_hold, irq;
	logic [2:0] bod_level;
	logic [4:0] margin_pct;
	logic [7:0] rd;
	logic [7:0] pct [4] = '{{3'h0, MARGIN_PCT_0}, {3'h0, MARGIN_PCT_1}, {3'h0, MARGIN_PCT_2}, 8'h00};
	int n_errors = 0;
	int num_checks = 0;
	// 50 MHz clock
	always #10 clk_i = ~clk_i;
	bsmc_top #(.SAMP_FAST_CYCLES(200), .SAMP_SLOW_CYCLES(400)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
		.wb_ack_o(wb_ack), .fuse_level_i(fuse_level), .fuse_active_i(fuse_active),
		.fuse_sleep_i(fuse_sleep), .fuse_sampfreq_i(fuse_sampfreq), .deep_sleep_i(deep_sleep),
		.debug_halt_i(debug_halt), .config_change_guard_i(guard), .bod_below_i(bod_below),
		.warn_below_i(warn_below), .bod_power_o(bod_power), .bod_level_o(bod_level),
		.warn_power_o(warn_power), .warn_margin_pct_o(margin_pct), .sys_reset_o(sys_reset),
		.cpu_hold_o(cpu_hold), .irq_o(irq));
	bsmc_supply_model supply (
		.clk_i(clk_i), .supply_lvl_i(supply_lvl), .bod_power_i(bod_power),
		.warn_power_i(warn_power), .bod_below_o(bod_below), .warn_below_o(warn_below));
	// verdict and end of run
	task wrap_up;
		if (n_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic fail(input string what);
		n_errors++;
		$display("[FAIL] %0t %s", $time, what);
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) fail(what);
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
	endtask
	task automatic chk_count(input int got, input int exp, input string what);
		num_checks++;
		if (got != exp) fail($sformatf("%s got %0d exp %0d", what, got, exp));
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb_xfer(input logic [3:0] idx, input logic we, input logic [7:0] d);
		int n;
		logic got_ack;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_sel <= 4'h1;
		wb_dat_w <= {24'h0, d};
		n = 0;
		do begin
			// ack and data are settled at the falling edge before the sampling edge
			@(negedge clk_i);
			got_ack = wb_ack;
			rd = wb_dat_r[7:0];
			@(posedge clk_i);
			n++;
		end while (got_ack !== 1'b1 && n < 16);
		if (got_ack !== 1'b1) begin
			fail("bus answer missing");
			wrap_up;
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	task automatic wb_wr(input logic [3:0] idx, input logic [7:0] d);
		wb_xfer(idx, 1'b1, d);
	endtask
	task automatic wb_rd(input logic [3:0] idx, input logic [7:0] exp, input string what);
		wb_xfer(idx, 1'b0, 8'h00);
		chk_byte(rd, exp, what);
	endtask
	// sleep field write inside an open unlock window
	task automatic guarded_wr(input logic [7:0] d);
		@(posedge clk_i) guard <= 1'b1;
		wb_wr(REG_MODE_CTRL, d);
		guard <= 1'b0;
	endtask
	// bounded wait: 0 irq, 1 reset request, 2 detector power
	task automatic wait_for(input int which, input logic val);
		int n;
		logic s;
		for (n = 0; n < 1000; n++) begin
			@(negedge clk_i);
			s = (which == 0) ? irq : (which == 1) ? sys_reset : bod_power;
			@(posedge clk_i);
			if (s === val) break;
		end
		num_checks++;
		if (n >= 1000) begin
			fail("wait ran out");
			wrap_up;
		end
	endtask
	// counts high cycles of detector power (hold 0) or of the wake hold (hold 1)
	task automatic count_power(input bit hold, input int cyc, input int exp, input string what);
		int n;
		n = 0;
		repeat (cyc) begin
			@(negedge clk_i);
			if ((hold ? cpu_hold : bod_power) === 1'b1) n++;
		end
		@(posedge clk_i);
		chk_count(n, exp, what);
	endtask
	initial begin
		tick(6);
		rst_i <= 1'b0;
		tick(2);
		// fuse copy and write protection
		chk_byte({5'h0, bod_level}, 8'h05, "level pin");
		wb_rd(REG_MODE_CTRL, 8'h06, "mode after reset");
		wb_rd(REG_LEVEL_CTRL, 8'h05, "level reg");
		wb_wr(REG_MODE_CTRL, 8'hff);
		wb_wr(REG_LEVEL_CTRL, 8'h00);
		wb_rd(REG_MODE_CTRL, 8'h06, "unguarded write");
		wb_rd(REG_LEVEL_CTRL, 8'h05, "level write");
		guarded_wr(8'h01);
		wb_rd(REG_MODE_CTRL, 8'h05, "guarded write");
		wb_rd(4'h3, 8'h00, "unmapped read");
		// every margin code, ending on code 0
		for (int i = 3; i >= 0; i--) begin
			wb_wr(REG_WARN_LEVEL, 8'(i));
			tick(2);
			chk_byte({3'h0, margin_pct}, pct[i], "margin pin");
		end
		// monitor, trigger below
		wb_wr(REG_WARN_IRQ_CTRL, 8'h01);
		tick(10);
		wb_wr(REG_WARN_FLAGS, 8'h01);
		wb_rd(REG_WARN_FLAGS, 8'h00, "flag idle");
		wb_rd(REG_WARN_IRQ_CTRL, 8'h01, "irq ctrl");
		chk_bit(warn_power, 1'b1, "monitor power");
		supply_lvl <= 2'h1;
		wait_for(0, 1'b1);
		wb_rd(REG_WARN_FLAGS, 8'h01, "flag below");
		wb_rd(REG_WARN_STATUS, 8'h01, "status below");
		debug_halt <= 1'b1;
		tick(3);
		chk_bit(irq, 1'b0, "debug mask");
		debug_halt <= 1'b0;
		supply_lvl <= 2'h0;
		wb_wr(REG_WARN_FLAGS, 8'h00);
		tick(3);
		chk_bit(irq, 1'b1, "irq holds");
		wb_wr(REG_WARN_FLAGS, 8'h01);
		tick(2);
		chk_bit(irq, 1'b0, "irq cleared");
		// trigger above, then either direction
		wb_wr(REG_WARN_IRQ_CTRL, 8'h03);
		supply_lvl <= 2'h1;
		tick(10);
		wb_rd(REG_WARN_FLAGS, 8'h00, "fall with above");
		supply_lvl <= 2'h0;
		wait_for(0, 1'b1);
		wb_wr(REG_WARN_FLAGS, 8'h01);
		wb_wr(REG_WARN_IRQ_CTRL, 8'h05);
		supply_lvl <= 2'h1;
		wait_for(0, 1'b1);
		wb_wr(REG_WARN_FLAGS, 8'h01);
		supply_lvl <= 2'h0;
		wait_for(0, 1'b1);
		// brown-out reset request
		supply_lvl <= 2'h2;
		wait_for(1, 1'b1);
		supply_lvl <= 2'h0;
		wait_for(1, 1'b0);
		wb_wr(REG_WARN_FLAGS, 8'h01);
		// sampled sleep, then wake
		guarded_wr(8'h02);
		deep_sleep <= 1'b1;
		tick(400);
		count_power(1'b0, 400, 2 * PROBE_ON_CYC, "sampled sleep");
		wb_rd(REG_WARN_FLAGS, 8'h00, "sampled monitor");
		deep_sleep <= 1'b0;
		tick(10);
		count_power(1'b0, 100, 100, "awake");
		wb_wr(REG_WARN_FLAGS, 8'h01);
		// detector off in sleep
		guarded_wr(8'h00);
		deep_sleep <= 1'b1;
		tick(10);
		chk_bit(warn_power, 1'b0, "monitor off");
		supply_lvl <= 2'h2;
		tick(20);
		chk_bit(sys_reset, 1'b0, "detector off");
		wb_rd(REG_WARN_FLAGS, 8'h00, "flag frozen");
		deep_sleep <= 1'b0;
		supply_lvl <= 2'h0;
		tick(10);
		// second reset: hold at wake, continuous sleep, slow sampling
		fuse_level <= 3'h2;
		fuse_active <= 2'h3;
		fuse_sleep <= 2'h1;
		fuse_sampfreq <= 1'b1;
		rst_i <= 1'b1;
		tick(6);
		rst_i <= 1'b0;
		tick(2);
		chk_byte({5'h0, bod_level}, 8'h02, "level pin again");
		wb_rd(REG_MODE_CTRL, 8'h1d, "mode after second reset");
		wb_wr(REG_WARN_IRQ_CTRL, 8'h07);
		supply_lvl <= 2'h1;
		tick(10);
		wb_rd(REG_WARN_FLAGS, 8'h00, "reserved trigger");
		supply_lvl <= 2'h0;
		deep_sleep <= 1'b1;
		tick(10);
		count_power(1'b0, 20, 20, "continuous sleep");
		deep_sleep <= 1'b0;
		count_power(1'b1, 150, STARTUP_CYC, "wake hold");
		guarded_wr(8'h02);
		deep_sleep <= 1'b1;
		tick(400);
		count_power(1'b0, 800, 2 * PROBE_ON_CYC, "slow sampled sleep");
		deep_sleep <= 1'b0;
		tick(10);
		wrap_up;
	end
endmodule
